// file: logic/spidg_pkg.sv
// Shared constants and types for the serial datagram slave
package spidg_pkg;

  // Datagram geometry
  localparam int unsigned DG_BITS    = 40;
  localparam int unsigned DATA_BITS  = 32;
  localparam int unsigned ADDR_BITS  = 7;
  localparam int unsigned STAT_BITS  = 8;
  localparam int unsigned CNT_BITS   = 6;
  localparam logic [5:0]  DG_BITS_C  = 6'h28;

  // Register addresses (7-bit register number)
  localparam logic [6:0] ADDR_DEAD_TIME = 7'h0A;  // Write-only
  localparam logic [6:0] ADDR_CHOPPER   = 7'h6C;  // Read-write
  localparam logic [6:0] ADDR_DRV_STAT  = 7'h6F;  // Read-only

  // Field layout and reset values
  localparam int unsigned HSSD_BIT        = 0;
  localparam int unsigned DT_BITS         = 8;
  localparam logic [31:0] CHOPPER_RESET   = 32'h0000_0000;
  localparam logic [7:0]  DEAD_TIME_RESET = 8'h04;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
  localparam logic [7:0]  ZERO_STAT       = 8'h00;

  // One received command
  typedef struct packed {
    logic                 write_flag;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } spidg_cmd_t;

  // Gate pair for one half bridge
  typedef struct packed {
    logic high;
    logic low;
  } spidg_gate_t;

endpackage

// file: logic/spidg_slave.sv
// Serial datagram slave: 40-bit framing, register access, gate dead time
//
// Operation
// - Each transaction is one 40-bit datagram: an address byte then four data bytes.
// - The address byte comes first and the 32-bit word follows it directly.
// - Every register moves as a full 32-bit word, unused upper bits meaningless.
// - Address byte top bit 0 means read, 1 means write; low seven bits are the address.
// - The register number is decoded from the address byte of every datagram.
// - Write-only, read-write and read-only registers exist; writes to read-only do nothing, write-only reads give zero.
// - A configuration bit turns off high-side short-to-supply detection.
// - Break-before-make dead time between high and low gate outputs is always generated.
// - Bits are shifted most significant first, bit 39 first and bit 0 last.
// - During the address byte the device shifts out an eight-bit status byte.
// - The returned word is the read value of the previous address, or the previous write data.
// - On select rising after at least forty bits, the last forty received are latched and executed.
`timescale 1ns/1ps
`default_nettype none

module spidg_slave
  import spidg_pkg::*;
#(
  parameter int unsigned DT_W = DT_BITS
) (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 sck_in,
  input  wire logic                 sdi_in,
  input  wire logic                 chip_select_low_n_in,
  input  wire logic [STAT_BITS-1:0] status_in,
  input  wire logic [DATA_BITS-1:0] drv_status_in,
  input  wire spidg_gate_t          gate_demand_in,
  output var  logic                 sdo_out,
  output var  logic                 sdo_oe_out,
  output var  logic                 cmd_valid_out,
  output var  spidg_cmd_t           cmd_out,
  output var  logic                 high_side_short_disable_out,
  output var  spidg_gate_t          gate_out
);

  // Reset release through two flip-flops
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pin inputs: select idles high, clock idles high (mode 3)
  logic [2:0] pins_s;
  logic       sck_s;
  logic       sdi_s;
  logic       cs_n_s;

  spidg_sync #(
    .WIDTH (3),
    .INIT  (3'h5)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .async_in ({chip_select_low_n_in, sdi_in, sck_in}),
    .sync_out (pins_s)
  );
  assign sck_s  = pins_s[0];
  assign sdi_s  = pins_s[1];
  assign cs_n_s = pins_s[2];

  // Edge detection on the synchronised copies
  logic sck_d_reg;
  logic cs_n_d_reg;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_reg  <= 1'b1;
      cs_n_d_reg <= 1'b1;
    end else begin
      sck_d_reg  <= sck_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic active;
  assign active   = ~cs_n_s;
  assign sck_rise = active & sck_s & ~sck_d_reg;
  assign sck_fall = active & ~sck_s & sck_d_reg;
  assign cs_fall  = ~cs_n_s & cs_n_d_reg;
  assign cs_rise  = cs_n_s & ~cs_n_d_reg;

  // Shift register, bit counter and pipelined reply
  logic [DG_BITS-1:0]   shift_reg;
  logic [CNT_BITS-1:0]  bit_cnt_reg;
  logic [DATA_BITS-1:0] reply_reg;
  logic [STAT_BITS-1:0] stat_reg;

  // Datagram view of the received bits
  spidg_cmd_t rx_cmd;
  logic       frame_ok;
  logic       exec;
  logic       exec_wr;
  assign rx_cmd   = spidg_cmd_t'(shift_reg);
  assign frame_ok = (bit_cnt_reg >= DG_BITS_C);
  assign exec     = cs_rise & frame_ok;
  assign exec_wr  = exec & rx_cmd.write_flag;

  // Address decode of the received register number
  logic hit_dead_time;
  logic hit_chopper;
  logic hit_drv_stat;
  assign hit_dead_time = (rx_cmd.addr == ADDR_DEAD_TIME);
  assign hit_chopper   = (rx_cmd.addr == ADDR_CHOPPER);
  assign hit_drv_stat  = (rx_cmd.addr == ADDR_DRV_STAT);

  // Register storage
  logic [DATA_BITS-1:0] chopper_reg;
  logic [DT_W-1:0]      dead_time_reg;

  // Read value: write-only and unmapped give zero
  logic [DATA_BITS-1:0] rd_value;
  assign rd_value = hit_chopper  ? chopper_reg   :
                    hit_drv_stat ? drv_status_in :
                    ZERO_WORD;

  // Reply for the next datagram: write data or read value
  logic [DATA_BITS-1:0] reply_next;
  assign reply_next = rx_cmd.write_flag ? rx_cmd.data : rd_value;

  // Serial shifting; bit 39 leaves first, sampled on clock rise
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (cs_fall) begin
      shift_reg <= {stat_reg, reply_reg};
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[DG_BITS-2:0], sdi_s};
    end
  end

  // Count bits, saturating; extra bits keep only the last forty
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= '0;
    end else if (cs_fall) begin
      bit_cnt_reg <= '0;
    end else if (sck_rise && !frame_ok) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
  end

  // Output bit changes after the falling clock edge
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sdo_out    <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else begin
      sdo_oe_out <= active;
      if (cs_fall) begin
        sdo_out <= stat_reg[STAT_BITS-1];
      end else if (sck_fall) begin
        sdo_out <= shift_reg[DG_BITS-1];
      end
    end
  end

  // Status and reply are latched at the end of each datagram
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg  <= ZERO_STAT;
      reply_reg <= ZERO_WORD;
    end else if (exec) begin
      stat_reg  <= status_in;
      reply_reg <= reply_next;
    end
  end

  // Register writes; read-only address ignores write data
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      chopper_reg   <= CHOPPER_RESET;
      dead_time_reg <= DEAD_TIME_RESET[DT_W-1:0];
    end else if (exec_wr) begin
      if (hit_chopper) begin
        chopper_reg <= rx_cmd.data;
      end
      if (hit_dead_time) begin
        dead_time_reg <= rx_cmd.data[DT_W-1:0];
      end
    end
  end

  // Command report and configuration bit outputs
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid_out               <= 1'b0;
      cmd_out                     <= '0;
      high_side_short_disable_out <= 1'b0;
    end else begin
      cmd_valid_out               <= exec;
      high_side_short_disable_out <= chopper_reg[HSSD_BIT];
      if (exec) begin
        cmd_out <= rx_cmd;
      end
    end
  end

  // Dead time: both gates off before the other side turns on
  spidg_gate_t     gate_target;
  logic            gate_change;
  logic            gate_any_on;
  logic [DT_W-1:0] dt_cnt_reg;
  logic            dt_busy;
  // Both demanded at once is treated as both off, never overlap
  assign gate_target.high = gate_demand_in.high & ~gate_demand_in.low;
  assign gate_target.low  = gate_demand_in.low & ~gate_demand_in.high;
  assign gate_change      = (gate_out != gate_target);
  assign gate_any_on      = gate_out.high | gate_out.low;
  assign dt_busy          = (dt_cnt_reg != '0);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gate_out   <= '0;
      dt_cnt_reg <= '0;
    end else if (gate_change && gate_any_on) begin
      gate_out   <= '0;
      dt_cnt_reg <= dead_time_reg;
    end else if (dt_busy) begin
      dt_cnt_reg <= dt_cnt_reg - 1'b1;
    end else if (gate_change) begin
      gate_out <= gate_target;
    end
  end

endmodule // spidg_slave

`default_nettype wire

// file: logic/spidg_sync.sv
// Two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module spidg_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // spidg_sync

`default_nettype wire

// file: tb/spidg_host_model.sv
// Host master model: mode 3 frames, clock parked high between them
`timescale 1ns/1ps
`default_nettype none

module spidg_host_model (
  input  wire logic sdo_in,
  output var  logic sck_out,
  output var  logic sdi_out,
  output var  logic csn_out
);
  initial begin
    sck_out = 1'b1;
    sdi_out = 1'b0;
    csn_out = 1'b1;
  end

  // Sends the low n bits of tx, top first; reply is sampled at sck rise
  task automatic xfer(input logic [47:0] tx, input int n,
                      output logic [39:0] rx);
    csn_out = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      sck_out = 1'b0;
      sdi_out = tx[i];
      #160 sck_out = 1'b1;
      rx = {rx[38:0], sdo_in};
      #160;
    end
    sdi_out = ~sdi_out; // Released line must not keep the last bit
    csn_out = 1'b1;
    #480;
  endtask
endmodule // spidg_host_model

`default_nettype wire

// file: tb/spidg_slave_assertions.sv
// Port-level checks for the serial datagram slave
`timescale 1ns/1ps
`default_nettype none

module spidg_slave_assertions
  import spidg_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        chip_select_low_n_in,
  input wire logic        sdo_oe_out,
  input wire logic        cmd_valid_out,
  input wire spidg_cmd_t  cmd_out,
  input wire logic        high_side_short_disable_out,
  input wire spidg_gate_t gate_out
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // Command side: single pulse, only after select went high
  valid_pulse_a: assert property (cmd_valid_out |=> !cmd_valid_out)
    else $error("command pulse longer than one cycle");
  valid_cause_a: assert property (cmd_valid_out |->
    $past(chip_select_low_n_in, 2) && $past(chip_select_low_n_in, 3))
    else $error("command executed while select was low");
  cmd_hold_a: assert property (!cmd_valid_out |-> $stable(cmd_out))
    else $error("command changed without a pulse");
  // Output enable follows select once synchronised
  oe_on_a: assert property ((!chip_select_low_n_in)[*6] |-> sdo_oe_out)
    else $error("serial output not enabled in frame");
  oe_off_a: assert property (chip_select_low_n_in[*6] |-> !sdo_oe_out)
    else $error("serial output enabled outside frame");
  // Bit 0 of the chopper word drives the disable output
  hssd_update_a: assert property ($changed(high_side_short_disable_out) |->
    $past(cmd_valid_out) && $past(cmd_out.write_flag)
    && $past(cmd_out.addr) == ADDR_CHOPPER
    && high_side_short_disable_out == $past(cmd_out.data[0]))
    else $error("disable bit changed without chopper write");
  // A shoot-through would destroy the bridge
  gate_excl_a: assert property (!(gate_out.high && gate_out.low))
    else $error("both gates on");
  gate_gap_a: assert property ($fell(gate_out.high) |-> (!gate_out.low)[*2])
    else $error("no dead time before low gate");
endmodule // spidg_slave_assertions

bind spidg_slave spidg_slave_assertions chk (.clk_in, .resetn_in,
  .chip_select_low_n_in, .sdo_oe_out, .cmd_valid_out, .cmd_out,
  .high_side_short_disable_out, .gate_out);

`default_nettype wire

// file: tb/spidg_slave_test.sv
// Self-checking bench for the serial datagram slave
`timescale 1ns/1ps
`default_nettype none

module spidg_slave_test;
  import spidg_pkg::*;
  localparam logic [31:0] DRV = 32'h5A5A_3C3C;
  logic        clk_in = 1'b0, resetn_in = 1'b0;
  logic        sck, sdi, chip_select_low, sdo, oe, vld, hssd;
  logic [7:0]  stat = 8'h00, lst = 8'h00;
  spidg_gate_t dem = '0, gate;
  spidg_cmd_t  cmd;
  int          fail_count = 0, n_compared = 0, pulses = 0, cyc = 0;

  always #20 clk_in = ~clk_in;

  spidg_slave dut (.clk_in, .resetn_in, .sck_in(sck), .sdi_in(sdi),
    .chip_select_low_n_in(chip_select_low), .status_in(stat), .drv_status_in(DRV),
    .gate_demand_in(dem), .sdo_out(sdo), .sdo_oe_out(oe),
    .cmd_valid_out(vld), .cmd_out(cmd),
    .high_side_short_disable_out(hssd), .gate_out(gate));
  spidg_host_model host (.sdo_in(sdo), .sck_out(sck), .sdi_out(sdi),
    .csn_out(chip_select_low));

  // Pulse counter and hang guard
  always @(posedge clk_in) begin
    pulses <= pulses + int'(vld);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One frame; a refused one must leave no command pulse
  task automatic frame(input logic [47:0] tx, input int n,
                       input logic [39:0] exp, input logic fire);
    logic [39:0] rx;
    int          p0;
    p0 = pulses;
    host.xfer(tx, n, rx);
    check(40'(pulses - p0), 40'(fire));
    if (fire) begin
      check(rx, exp);
      check(cmd, tx[39:0]);
      lst = stat;
    end
    @(negedge clk_in);
    stat = stat + 8'h11;
  endtask

  // Access kinds, echo after writes, pipelined reads
  task automatic t_regs();
    logic [39:0] tx [10];
    logic [31:0] ex [10];
    tx = '{40'hEC_0000_0001, 40'h6C_FFFF_FFFF, 40'h6F_0000_0000,
           40'h0A_0000_0000, 40'h8A_0000_0007, 40'hEF_1234_5678,
           40'h6F_0000_0000, 40'h11_0000_0000, 40'hEC_0000_0000,
           40'h6C_0000_0000};
    ex = '{32'h0, 32'h1, 32'h1, DRV, 32'h0, 32'h7, 32'h1234_5678, DRV,
           32'h0, 32'h0};
    for (int i = 0; i < 10; i++) begin
      frame({8'h00, tx[i]}, 40, {lst, ex[i]}, 1'b1);
      check(40'(hssd), 40'(i < 8));
    end
  endtask

  // Short frame refused, long frame keeps its last forty bits
  task automatic t_frames();
    frame({8'h00, 40'hEC_0000_0001}, 20, '0, 1'b0);
    frame({8'hFF, 40'hEC_0000_0001}, 48, {32'h0, 8'hFF}, 1'b1);
    check(40'(hssd), 40'h1);
  endtask

  // Changeover waits the programmed dead time; both demanded is refused
  task automatic t_gates();
    int off;
    @(negedge clk_in);
    dem = 2'b10;
    repeat (30) @(negedge clk_in);
    check(40'(gate), 40'h2);
    dem = 2'b01;
    off = 0;
    repeat (30) begin
      @(negedge clk_in);
      off += int'(gate == 2'b00);
    end
    check(40'(gate), 40'h1);
    check(40'(off >= 7), 40'h1);
    dem = 2'b11;
    repeat (30) @(negedge clk_in);
    check(40'(gate), 40'h0);
  endtask

  initial begin
    repeat (20) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (8) @(negedge clk_in);
    t_regs();
    t_frames();
    t_gates();
    report_and_stop();
  end
endmodule // spidg_slave_test

`default_nettype wire
